// *** hw/pin_ctl_pkg.sv ***
`default_nettype none
package pin_ctl_pkg;
  localparam int MIO_W = 32;
  localparam int IO_W = 7;
  localparam int VDAT_W = 4;
  localparam int SER_IN_W = 4;
  localparam int SER_OUT_W = 6;

  // Reset values of the select, enable and overlay controls.
  localparam logic [31:0] MIOSEL_RST = 32'hF20F_0FFF;
  localparam logic [31:0] MIOPD_RST = 32'hFAFF_3FFF;
  localparam logic [6:0] IOPD_RST = 7'h7F;
  localparam logic OVERLAY_RST = 1'b0;

  // Pin index of the bus grant line among the shareable pins.
  localparam int GRANT_PIN = 26;

  // Selector codes of the control write port.
  typedef enum logic [1:0] {
    CFG_MIOSEL = 2'b00,
    CFG_MIOPD = 2'b01,
    CFG_IOPD = 2'b10,
    CFG_OVERLAY = 2'b11
  } cfg_sel_t;

  // Power states of the device.
  typedef enum logic [1:0] {
    ST_PON = 2'b00,
    ST_RUN = 2'b01,
    ST_SLEEP = 2'b10
  } pwr_state_t;

  // Memory interface pin group, strobes active low as on the board.
  typedef struct packed {
    logic [31:0] data;
    logic [12:0] addr;
    logic ale;
    logic rdN;
    logic weN;
    logic [3:0] casN;
    logic ras0N;
    logic ras1N;
    logic dcs0N;
    logic dcke;
    logic dclkOut;
    logic dqmh;
    logic dqml;
  } mem_pins_t;

  // Chip selects; only cs0N is floated by the bus grant and held high on wake, cs13N is unused.
  typedef struct packed {
    logic cs0N;
    logic [2:0] cs13N;
  } chip_sel_t;

  // Interrupt debug probe group.
  typedef struct packed {
    logic busErr;
    logic cpuStall;
    logic irqHigh;
    logic irqLow;
  } probe_t;
endpackage
`default_nettype wire

// *** hw/pin_cell.sv ***
`default_nettype none
module pin_cell
  import pin_ctl_pkg::*;
(
  // Standard function side.
  input wire logic stdOut,
  input wire logic stdOe,
  output logic stdIn,
  // Multi-function side.
  input wire logic mioOut,
  input wire logic mioOe,
  output logic mioIn,
  // Controls.
  input wire logic sel,
  input wire logic forceDown,
  // Pad side.
  input wire logic padIn,
  output logic padOut,
  output logic padOe,
  output logic pullDn
);
  logic oeSel;
  logic outSel;

  // The select bit steers both directions of the pin.
  assign outSel = sel ? mioOut : stdOut;
  assign oeSel = sel ? mioOe : stdOe;
  assign stdIn = sel ? 1'b0 : padIn;
  assign mioIn = sel ? padIn : 1'b0;

  // A forced output drives low; a forced input gets a pull-down so it never floats.
  assign padOut = forceDown ? 1'b0 : outSel;
  assign padOe = oeSel;
  assign pullDn = forceDown & ~oeSel;
endmodule
`default_nettype wire

// *** hw/pin_function_and_powerdown_control.sv ***
`default_nettype none
module pin_function_and_powerdown_control
  import pin_ctl_pkg::*;
(
  // Clock and power-on reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Control write port and readback.
  input wire logic cfgWe,
  input wire logic [1:0] cfgSel,
  input wire logic [31:0] cfgWdata,
  output logic [31:0] mioSelOut,
  output logic [31:0] mioPdOut,
  output logic [6:0] ioPdOut,
  output logic interrupt_debug_overlay,
  // Power sequencing.
  input wire logic onButton,
  input wire logic sleepReq,
  input wire logic system_supply_good,
  input wire logic standby_supply,
  output logic supplyOnReq,
  output logic powerDown,
  output logic [1:0] pwrState,
  output logic sysOscEn,
  output logic osc32kEn,
  // Memory controller side and memory pads.
  input wire mem_pins_t memCtl,
  input wire logic memDataOe,
  input wire chip_sel_t csCtl,
  input wire logic ctlReady,
  output mem_pins_t memPadOut,
  output logic memPadOe,
  output logic memDataPadOe,
  output logic cs0PadOut,
  output logic cs0PadOe,
  output logic cs0Pull,
  // External bus arbitration.
  input wire logic busReq,
  output logic busGrant,
  // Shareable pins.
  input wire logic [31:0] stdOut,
  input wire logic [31:0] stdOe,
  output logic [31:0] stdIn,
  input wire logic [31:0] mioOut,
  input wire logic [31:0] mioOe,
  output logic [31:0] mioIn,
  input wire logic [31:0] mioPadIn,
  output logic [31:0] mioPadOut,
  output logic [31:0] mioPadOe,
  output logic [31:0] mioPull,
  // General I/O pins.
  input wire logic [6:0] ioOut,
  input wire logic [6:0] ioOe,
  output logic [6:0] ioPadOut,
  output logic [6:0] ioPadOe,
  output logic [6:0] ioPull,
  // Video data and debug probes.
  input wire logic [3:0] vdatIn,
  input wire probe_t probes,
  output logic [3:0] vdatPad,
  // Serial outputs and inputs that sleep forces.
  input wire logic [5:0] serOut,
  output logic [5:0] serPadOut,
  output logic [3:0] serInPull
);
  logic [31:0] mioSel_ff;
  logic [31:0] mioPd_ff;
  logic [6:0] ioPd_ff;
  logic overlay_ff;
  pwr_state_t state_ff;
  pwr_state_t nxt_state;
  logic wakeHold_ff;
  logic grant_ff;
  logic pdGlobal;
  logic [31:0] forceMio;
  logic [31:0] stdOutEff;
  logic [31:0] stdOeEff;
  logic [31:0] cellOut;
  logic [31:0] cellOe;
  logic [31:0] cellPull;
  mem_pins_t memOut_ff;
  logic memOe_ff;
  logic memDataOe_ff;
  logic [31:0] mioPadOut_ff;
  logic [31:0] mioPadOe_ff;
  logic [31:0] mioPull_ff;
  logic [6:0] ioPadOut_ff;
  logic [6:0] ioPadOe_ff;
  logic [6:0] ioPull_ff;
  logic [3:0] vdat_ff;
  logic [5:0] ser_ff;
  logic cs0Out_ff;
  logic cs0Oe_ff;
  logic cs0Pull_ff;

  // Control storage is cleared only by power-on reset, so whatever software
  // programs after the first power-up survives every sleep and wake.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mioSel_ff <= MIOSEL_RST;
      mioPd_ff <= MIOPD_RST;
      ioPd_ff <= IOPD_RST;
      overlay_ff <= OVERLAY_RST;
    end
    else if (cfgWe)
    begin
      case (cfg_sel_t'(cfgSel))
        CFG_MIOSEL: mioSel_ff <= cfgWdata;
        CFG_MIOPD: mioPd_ff <= cfgWdata;
        CFG_IOPD: ioPd_ff <= cfgWdata[6:0];
        CFG_OVERLAY: overlay_ff <= cfgWdata[0];
        default: overlay_ff <= overlay_ff;
      endcase
    end
  end

  assign mioSelOut = mioSel_ff;
  assign mioPdOut = mioPd_ff;
  assign ioPdOut = ioPd_ff;
  assign interrupt_debug_overlay = overlay_ff;

  // Power state sequencing; running is reached only through the on button.
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_PON:
      begin
        if (onButton)
          nxt_state = ST_RUN;
      end
      ST_RUN:
      begin
        if (sleepReq)
          nxt_state = ST_SLEEP;
      end
      ST_SLEEP:
      begin
        if (onButton)
          nxt_state = ST_RUN;
      end
      default: nxt_state = ST_PON;
    endcase
  end

  // Without standby supply nothing can run, so the device stays in power-on.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= ST_PON;
    else if (!standby_supply)
      state_ff <= ST_PON;
    else
      state_ff <= nxt_state;
  end

  // On each entry to running the read strobe and chip select 0 are held at their idle high level
  // until the memory controller reports it is ready to drive them.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      wakeHold_ff <= 1'b0;
    else if (state_ff != ST_RUN && nxt_state == ST_RUN && standby_supply)
      wakeHold_ff <= 1'b1;
    else if (ctlReady || state_ff != ST_RUN)
      wakeHold_ff <= 1'b0;
  end

  // The supply request is high only while running; global powerdown follows.
  assign supplyOnReq = (state_ff == ST_RUN);
  assign pdGlobal = ~(supplyOnReq & system_supply_good);
  assign powerDown = pdGlobal;
  assign pwrState = state_ff;
  assign sysOscEn = ~pdGlobal;
  assign osc32kEn = 1'b1;

  // Bus grant answers an external request only while the bus is alive.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      grant_ff <= 1'b0;
    else
      grant_ff <= busReq & ~pdGlobal & ~wakeHold_ff;
  end

  // Grant pin is active low on the pad and idles high once running.
  assign busGrant = grant_ff;

  // Per-pin forcing needs both the global condition and the pin's enable.
  assign forceMio = {MIO_W{pdGlobal}} & mioPd_ff;

  // The grant pin's standard function is owned here, not by a peripheral.
  always_comb
  begin
    stdOutEff = stdOut;
    stdOeEff = stdOe;
    stdOutEff[GRANT_PIN] = ~grant_ff | wakeHold_ff;
    stdOeEff[GRANT_PIN] = 1'b1;
  end

  // One cell per shareable pin.
  for (genvar i = 0; i < MIO_W; i++)
  begin : g_cell
    pin_cell u_cell (
      .stdOut(stdOutEff[i]),
      .stdOe(stdOeEff[i]),
      .stdIn(stdIn[i]),
      .mioOut(mioOut[i]),
      .mioOe(mioOe[i]),
      .mioIn(mioIn[i]),
      .sel(mioSel_ff[i]),
      .forceDown(forceMio[i]),
      .padIn(mioPadIn[i]),
      .padOut(cellOut[i]),
      .padOe(cellOe[i]),
      .pullDn(cellPull[i])
    );
  end

  // Shareable and general I/O pads are registered toward the board.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mioPadOut_ff <= 32'h0000_0000;
      mioPadOe_ff <= 32'h0000_0000;
      mioPull_ff <= 32'hFFFF_FFFF;
      ioPadOut_ff <= 7'h00;
      ioPadOe_ff <= 7'h00;
      ioPull_ff <= 7'h7F;
    end
    else
    begin
      mioPadOut_ff <= cellOut;
      mioPadOe_ff <= cellOe;
      mioPull_ff <= cellPull;
      for (int k = 0; k < IO_W; k++)
      begin
        ioPadOut_ff[k] <= (pdGlobal & ioPd_ff[k]) ? 1'b0 : ioOut[k];
        ioPadOe_ff[k] <= ioOe[k];
        ioPull_ff[k] <= pdGlobal & ioPd_ff[k] & ~ioOe[k];
      end
    end
  end

  assign mioPadOut = mioPadOut_ff;
  assign mioPadOe = mioPadOe_ff;
  assign mioPull = mioPull_ff;
  assign ioPadOut = ioPadOut_ff;
  assign ioPadOe = ioPadOe_ff;
  assign ioPull = ioPull_ff;

  // Memory pins: low while powered down, idle-high read strobe and chip select 0 on wake,
  // floated whenever an external master holds the bus.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      memOut_ff <= '0;
      memOe_ff <= 1'b1;
      memDataOe_ff <= 1'b1;
      cs0Out_ff <= 1'b0;
      cs0Oe_ff <= 1'b0;
      cs0Pull_ff <= 1'b1;
    end
    else if (pdGlobal)
    begin
      // A grant still standing as sleep begins keeps the bus floated.
      memOut_ff <= '0;
      memOe_ff <= ~grant_ff;
      memDataOe_ff <= ~grant_ff;
      cs0Out_ff <= 1'b0;
      cs0Oe_ff <= 1'b0;
      cs0Pull_ff <= 1'b1;
    end
    else
    begin
      memOut_ff <= memCtl;
      if (wakeHold_ff)
        memOut_ff.rdN <= 1'b1;
      memOe_ff <= ~grant_ff;
      memDataOe_ff <= ~grant_ff & (memDataOe | wakeHold_ff);
      cs0Out_ff <= csCtl.cs0N | wakeHold_ff;
      cs0Oe_ff <= ~grant_ff;
      cs0Pull_ff <= 1'b0;
    end
  end

  assign memPadOut = memOut_ff;
  assign memPadOe = memOe_ff;
  assign memDataPadOe = memDataOe_ff;
  assign cs0PadOut = cs0Out_ff;
  assign cs0PadOe = cs0Oe_ff;
  assign cs0Pull = cs0Pull_ff;

  // Video data carries the debug probes while the overlay is set.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      vdat_ff <= 4'h0;
    else if (overlay_ff)
      vdat_ff <= probes;
    else
      vdat_ff <= vdatIn;
  end

  assign vdatPad = vdat_ff;

  // Serial outputs go low and serial and infrared inputs are pulled down
  // while powered down, so nothing floats into a dead peripheral.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ser_ff <= 6'h00;
      serInPull <= 4'hF;
    end
    else
    begin
      ser_ff <= pdGlobal ? 6'h00 : serOut;
      serInPull <= {SER_IN_W{pdGlobal}};
    end
  end

  assign serPadOut = ser_ff;
endmodule
`default_nettype wire

// *** bench/pin_ctl_chk.sv ***
`default_nettype none
module pin_ctl_chk
  import pin_ctl_pkg::*;
(
  // Clock, reset and controls.
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cfgWe,
  input wire logic [1:0] cfgSel,
  input wire logic [31:0] cfgWdata,
  input wire logic [31:0] mioSelOut,
  input wire logic [31:0] mioPdOut,
  input wire logic interrupt_debug_overlay,
  // Power.
  input wire logic onButton,
  input wire logic system_supply_good,
  input wire logic supplyOnReq,
  input wire logic powerDown,
  input wire logic [1:0] pwrState,
  input wire logic sysOscEn,
  input wire logic osc32kEn,
  // Pads.
  input wire mem_pins_t memPadOut,
  input wire logic memPadOe,
  input wire logic cs0PadOe,
  input wire logic [5:0] serPadOut,
  input wire logic busGrant,
  input wire logic [31:0] stdOut,
  input wire logic [31:0] mioOut,
  input wire logic [31:0] mioPadOut,
  input wire probe_t probes,
  input wire logic [3:0] vdatPad
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // Pin 26 carries the grant, so it is left out of the routing check.
  localparam logic [31:0] SKIP = 32'hFBFF_FFFF;
  logic [31:0] routed;
  assign routed = (mioSelOut & mioOut) | (~mioSelOut & stdOut);

  pd_equation_a: assert property (powerDown == !(supplyOnReq && system_supply_good))
    else $error("powerdown mismatch");
  osc_follow_a: assert property (sysOscEn == !powerDown && osc32kEn)
    else $error("oscillator enable mismatch");
  button_only_a: assert property (pwrState == ST_PON && !onButton |=> pwrState != ST_RUN)
    else $error("running without button");
  grant_float_a: assert property (busGrant |=> !memPadOe && !cs0PadOe)
    else $error("memory pads driven under grant");
  route_pin_a: assert property (!$past(powerDown) |-> ((mioPadOut ^ $past(routed)) & SKIP) == 0)
    else $error("pin routing mismatch");
  force_low_a: assert property ($past(powerDown) |-> (mioPadOut & $past(mioPdOut)) == 0)
    else $error("forced pin not low");
  mem_sleep_a: assert property ($past(powerDown) |-> memPadOut == '0 && serPadOut == '0)
    else $error("memory or serial pad not low");
  overlay_probe_a: assert property ($past(interrupt_debug_overlay) && !$past(powerDown)
    |-> vdatPad == $past(probes)) else $error("probe overlay mismatch");
  cfg_write_a: assert property (cfgWe && cfgSel == CFG_MIOSEL |=> mioSelOut == $past(cfgWdata))
    else $error("select write lost");

  // Main scenarios that the bench is expected to reach.
  grant_c: cover property (busGrant);
  run_c: cover property (pwrState == ST_RUN && !powerDown);
  overlay_c: cover property (interrupt_debug_overlay && !powerDown);
endmodule
bind pin_function_and_powerdown_control pin_ctl_chk chk (.*);
`default_nettype wire

// *** bench/far_side_model.sv ***
`default_nettype none
module far_side_model (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Supply request and bus wish.
  input wire logic supplyOnReq,
  input wire logic wantBus,
  // Answers.
  output logic system_supply_good,
  output logic busReq
);
  timeunit 1ns;
  timeprecision 1ps;
  // The supply answers a cycle late, since a real regulator ramps rather than snaps.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      system_supply_good <= 1'h0;
      busReq <= 1'h0;
    end
    else
    begin
      system_supply_good <= supplyOnReq;
      busReq <= wantBus;
    end
  end
endmodule
`default_nettype wire

// *** bench/tb.sv ***
`default_nettype none
module tb import pin_ctl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst_n = 0, cfgWe = 0, onButton = 0, sleepReq = 0, standby_supply = 1;
  logic memDataOe = 0, ctlReady = 0, wantBus = 0;
  logic [1:0] cfgSel = 0;
  logic [31:0] cfgWdata = 0, stdOe = 0, mioOe = 0, mioPadIn = 32'h3C3C_3C3C;
  logic [31:0] stdOut = 32'hA5A5_A5A5, mioOut = 32'h5A5A_5A5A;
  mem_pins_t memCtl = '0;
  chip_sel_t csCtl = '0;
  probe_t probes = '0;
  logic [6:0] ioOut = 7'h55, ioOe = 0, ioPdOut, ioPadOut, ioPadOe, ioPull;
  logic [3:0] vdatIn = 4'h5, vdatPad, serInPull;
  logic [5:0] serOut = 6'h3F, serPadOut;
  logic [31:0] mioSelOut, mioPdOut, stdIn, mioIn, mioPadOut, mioPadOe, mioPull;
  logic interrupt_debug_overlay, system_supply_good, supplyOnReq, powerDown, sysOscEn, osc32kEn;
  logic memPadOe, memDataPadOe, cs0PadOut, cs0PadOe, cs0Pull, busReq, busGrant;
  logic [1:0] pwrState;
  mem_pins_t memPadOut;
  logic [31:0] sels [2] = '{32'h0000_FFFF, 32'hFFFF_0000};
  int err_count = 0, comparisons = 0;

  always #12.5 mclk = ~mclk;
  pin_function_and_powerdown_control dut (.*);
  far_side_model far (.*);

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Inputs always move 2 ns after the edge so no race with the sampling edge.
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  task automatic cfg(input logic [1:0] s, input logic [31:0] d);
    cfgWe = 1;
    cfgSel = s;
    cfgWdata = d;
    tick(1);
    cfgWe = 0;
  endtask

  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // The whole run is a few dozen cycles, so this span only trips on a hang.
  initial
  begin
    #50us;
    err_count++;
    report_and_stop();
  end

  initial
  begin
    tick(8);
    rst_n = 1;
    chk(mioSelOut, MIOSEL_RST);
    chk(mioPdOut, MIOPD_RST);
    chk({ioPdOut, interrupt_debug_overlay}, {IOPD_RST, OVERLAY_RST});
    tick(3);
    chk(pwrState, ST_PON);
    chk(memPadOut, 0);
    chk(mioPull, MIOPD_RST);
    chk({sysOscEn, osc32kEn}, 2'h1);
    chk({ioPadOut, ioPull, serInPull}, {7'h00, 7'h7F, 4'hF});
    onButton = 1;
    tick(1);
    onButton = 0;
    chk(pwrState, ST_RUN);
    tick(2);
    chk({powerDown, sysOscEn, memPadOut.rdN, cs0PadOut, mioPadOut[26]}, 5'hF);
    chk({ioPadOut, ioPull, serPadOut, serInPull}, {7'h55, 7'h00, 6'h3F, 4'h0});
    // Each select pattern must steer every pin but the grant pin 26 to the matching source.
    foreach (sels[i])
    begin
      cfg(CFG_MIOSEL, sels[i]);
      chk(mioSelOut, sels[i]);
      chk({stdIn, mioIn}, {~sels[i] & mioPadIn, sels[i] & mioPadIn});
      tick(1);
      chk(mioPadOut & 32'hFBFF_FFFF, ((sels[i] & mioOut) | (~sels[i] & stdOut)) & 32'hFBFF_FFFF);
    end
    probes = 4'hA;
    cfg(CFG_OVERLAY, 32'h1);
    tick(1);
    chk(vdatPad, 4'hA);
    cfg(CFG_OVERLAY, 32'h0);
    tick(1);
    chk(vdatPad, 4'h5);
    ctlReady = 1;
    tick(2);
    wantBus = 1;
    repeat (20) if (busGrant !== 1'h1) tick(1);
    chk(busGrant, 1);
    tick(1);
    chk({memPadOe, memDataPadOe, cs0PadOe}, 3'h0);
    wantBus = 0;
    tick(4);
    sleepReq = 1;
    tick(1);
    sleepReq = 0;
    chk(pwrState, ST_SLEEP);
    tick(1);
    chk(memPadOut, 0);
    chk({serPadOut, cs0Pull, sysOscEn, osc32kEn}, {6'h0, 3'h5});
    chk(mioPadOut & MIOPD_RST, 0);
    chk(mioPadOut & 32'h0100_C000,
        ((sels[1] & mioOut) | (~sels[1] & stdOut)) & 32'h0100_C000);
    chk({ioPadOut, ioPull, serInPull}, {7'h00, 7'h7F, 4'hF});
    chk(mioSelOut, sels[1]);
    onButton = 1;
    tick(1);
    onButton = 0;
    tick(3);
    chk({pwrState, mioSelOut}, {ST_RUN, sels[1]});
    report_and_stop();
  end
endmodule
`default_nettype wire
